/* File: rtl/out_disable_pkg.sv */
package out_disable_pkg;

  localparam int NUM_DRV = 7;
  localparam int NUM_PIN = 3;
  localparam int NUM_LOOP = 4;

  // register byte addresses
  localparam logic [15:0] ADDR_STAT_CAL = 16'h000C;
  localparam logic [15:0] ADDR_STAT_LOCK = 16'h000D;
  localparam logic [15:0] ADDR_GATE = 16'h0102;
  localparam logic [15:0] ADDR_XMASK = 16'h0141;
  localparam logic [15:0] ADDR_LMASK = 16'h0142;
  localparam logic [15:0] ADDR_PINMAP_BASE = 16'h0150;
  localparam logic [15:0] ADDR_LOOPSEL_BASE = 16'h0160;
  localparam logic [15:0] ADDR_DRV_STAT = 16'h0170;
  localparam logic [NUM_DRV-1:0][15:0] ADDR_EN = {
    16'h013A, 16'h0130, 16'h012B, 16'h0126, 16'h011C, 16'h0117, 16'h0112};
  localparam logic [NUM_DRV-1:0][15:0] ADDR_CFG = {
    16'h013B, 16'h0131, 16'h012C, 16'h0127, 16'h011D, 16'h0118, 16'h0113};
  localparam logic [NUM_DRV-1:0][15:0] ADDR_SUP = {
    16'h013D, 16'h0133, 16'h012E, 16'h0129, 16'h011F, 16'h011A, 16'h0115};

  // field positions
  localparam int BIT_GATE = 0;
  localparam int BIT_EN = 1;
  localparam int BIT_SYNC = 3;
  localparam int IDLE_LSB = 4;
  localparam int IDLE_MSB = 5;
  localparam int BIT_SUPV = 3;
  localparam int SUP_LSB = 4;
  localparam int SUP_MSB = 5;
  localparam int BIT_XMASK = 6;
  localparam int BIT_XSTAT = 1;
  localparam int BIT_CALSTAT = 0;

  // reset values and codes
  localparam logic GATE_RST = 1'b1;
  localparam logic EN_RST = 1'b1;
  localparam logic SYNC_RST = 1'b0;
  localparam logic SUPV_RST = 1'b1;
  localparam logic XMASK_RST = 1'b0;
  localparam logic [3:0] LMASK_RST = 4'hF;
  localparam logic [1:0] IDLE_RST = 2'h0;
  localparam logic [1:0] IDLE_HIGH_CODE = 2'h1;
  localparam logic [1:0] SUP_RST = 2'h0;
  localparam logic [1:0] SUP_RESERVED = 2'h3;
  localparam logic [1:0] LOOPSEL_RST = 2'h0;
  localparam logic [6:0] PINMAP0_RST = 7'h7F;
  localparam logic [6:0] PINMAP_OTHER_RST = 7'h00;
  localparam logic [7:0] RDATA_ZERO = 8'h00;

  typedef struct packed {
    logic [NUM_DRV-1:0] drv_clk;
    logic [NUM_LOOP-1:0] lock_loss;
    logic crystal_loss;
    logic [NUM_PIN-1:0] pin_n;
  } async_in_type;

  localparam int ASYNC_W = $bits(async_in_type);

  typedef enum logic [1:0] {
    DRV_ON = 2'b01,
    DRV_OFF = 2'b10
  } drv_state_type;

endpackage : out_disable_pkg

/* File: rtl/output_disable_control.sv */
`timescale 1ns/1ps
// Contract
// - crystal loss alarm is an output disable source
// - idle-level field picks low or high when disabled
// - global gate 0 disables all, 1 defers
// - high enable pin disables its mapped drivers
// - driver enabled only with bit set, pin low
// - lock-loss mask 0 disables loop's drivers, default 1
// - crystal mask 0 disables on alarm, default
// - synchronous mode lets current period finish
// - asynchronous mode forces idle level at once
// - mode bit 1 sync, 0 async, resets 0
// - any unmasked source disables, sources ORed
// - calibration flag disables, not maskable
// - supply field 0 3.3V 1 1.8V 2 2.5V
// - after reset pin 0 maps all drivers
// - disabled driver keeps common mode, not powered down
module output_disable_control
  import out_disable_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // asynchronous sources and driver clocks
  input wire async_in_type async_in,
  input wire logic calibration_busy_flag,
  // driver side
  output logic [NUM_DRV-1:0] drv_out,
  output logic [NUM_DRV-1:0] drv_active,
  output logic [NUM_DRV-1:0] drv_cm_keep,
  output logic [NUM_DRV-1:0][1:0] driver_supply_level
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [NUM_DRV-1:0] drv_hit(
    input logic [15:0] addr,
    input logic [NUM_DRV-1:0][15:0] tbl
  );
    logic [NUM_DRV-1:0] hit;
    hit = '0;
    for (int k = 0; k < NUM_DRV; k++) begin
      hit[k] = (addr == tbl[k]);
    end
    return hit;
  endfunction : drv_hit
  function automatic logic [15:0] base_plus(
    input logic [15:0] base,
    input int k
  );
    return base + 16'(k);
  endfunction : base_plus

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [ASYNC_W-1:0] sync1_ff;
  logic [ASYNC_W-1:0] sync2_ff;
  logic [ASYNC_W-1:0] sync3_ff;
  logic [ASYNC_W-1:0] stable_ff;
  async_in_type in_st;
  // third stage lets a change count only once two stages agree
  always_ff @(posedge mclk) begin
    sync1_ff <= async_in;
    sync2_ff <= sync1_ff;
    sync3_ff <= sync2_ff;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stable_ff <= '0;
    end else begin
      for (int b = 0; b < ASYNC_W; b++) begin
        if (sync2_ff[b] == sync3_ff[b]) begin
          stable_ff[b] <= sync3_ff[b];
        end
      end
    end
  end

  assign in_st = async_in_type'(stable_ff);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic gate_ff;
  logic xmask_ff;
  logic [NUM_LOOP-1:0] lmask_ff;
  logic [NUM_DRV-1:0] en_ff;
  logic [NUM_DRV-1:0] sync_mode_ff;
  logic [NUM_DRV-1:0][1:0] idle_ff;
  logic [NUM_DRV-1:0][1:0] sup_ff;
  logic [NUM_DRV-1:0] supv_ff;
  logic [NUM_PIN-1:0][NUM_DRV-1:0] pinmap_ff;
  logic [NUM_DRV-1:0][1:0] loopsel_ff;
  logic [NUM_DRV-1:0] hit_en;
  logic [NUM_DRV-1:0] hit_cfg;
  logic [NUM_DRV-1:0] hit_sup;
  assign hit_en = drv_hit(reg_addr, ADDR_EN);
  assign hit_cfg = drv_hit(reg_addr, ADDR_CFG);
  assign hit_sup = drv_hit(reg_addr, ADDR_SUP);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gate_ff <= GATE_RST;
      xmask_ff <= XMASK_RST;
      lmask_ff <= LMASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_GATE) begin
        gate_ff <= reg_wdata[BIT_GATE];
      end
      if (reg_addr == ADDR_XMASK) begin
        xmask_ff <= reg_wdata[BIT_XMASK];
      end
      if (reg_addr == ADDR_LMASK) begin
        lmask_ff <= reg_wdata[NUM_LOOP-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      en_ff <= {NUM_DRV{EN_RST}};
      sync_mode_ff <= {NUM_DRV{SYNC_RST}};
      idle_ff <= {NUM_DRV{IDLE_RST}};
    end else if (reg_wr) begin
      for (int k = 0; k < NUM_DRV; k++) begin
        if (hit_en[k]) begin
          en_ff[k] <= reg_wdata[BIT_EN];
        end
        if (hit_cfg[k]) begin
          sync_mode_ff[k] <= reg_wdata[BIT_SYNC];
          idle_ff[k] <= reg_wdata[IDLE_MSB:IDLE_LSB];
        end
      end
    end
  end

  // reserved supply code is refused so the level always stays legal
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sup_ff <= {NUM_DRV{SUP_RST}};
      supv_ff <= {NUM_DRV{SUPV_RST}};
    end else if (reg_wr) begin
      for (int k = 0; k < NUM_DRV; k++) begin
        if (hit_sup[k]) begin
          supv_ff[k] <= reg_wdata[BIT_SUPV];
          if (reg_wdata[SUP_MSB:SUP_LSB] != SUP_RESERVED) begin
            sup_ff[k] <= reg_wdata[SUP_MSB:SUP_LSB];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pinmap_ff[0] <= PINMAP0_RST;
      for (int p = 1; p < NUM_PIN; p++) begin
        pinmap_ff[p] <= PINMAP_OTHER_RST;
      end
      loopsel_ff <= {NUM_DRV{LOOPSEL_RST}};
    end else if (reg_wr) begin
      for (int p = 0; p < NUM_PIN; p++) begin
        if (reg_addr == base_plus(ADDR_PINMAP_BASE, p)) begin
          pinmap_ff[p] <= reg_wdata[NUM_DRV-1:0];
        end
      end
      for (int k = 0; k < NUM_DRV; k++) begin
        if (reg_addr == base_plus(ADDR_LOOPSEL_BASE, k)) begin
          loopsel_ff[k] <= reg_wdata[1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // disable sources
  logic [NUM_DRV-1:0] dis_req;
  logic [NUM_DRV-1:0] pin_dis;
  logic [NUM_DRV-1:0] lock_dis;
  logic xtal_dis;
  assign xtal_dis = in_st.crystal_loss & ~xmask_ff;

  always_comb begin
    pin_dis = '0;
    lock_dis = '0;
    dis_req = '0;
    for (int k = 0; k < NUM_DRV; k++) begin
      for (int p = 0; p < NUM_PIN; p++) begin
        pin_dis[k] = pin_dis[k] | (pinmap_ff[p][k] & in_st.pin_n[p]);
      end
      lock_dis[k] = in_st.lock_loss[loopsel_ff[k]]
                    & ~lmask_ff[loopsel_ff[k]];
      // plain OR; any single source is enough
      dis_req[k] = ~gate_ff | ~en_ff[k] | pin_dis[k] | lock_dis[k]
                   | xtal_dis | calibration_busy_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-driver gating
  drv_state_type state_ff [NUM_DRV];
  logic [NUM_DRV-1:0] idle_hi;
  logic [NUM_DRV-1:0] drv_out_ff;
  logic [NUM_DRV-1:0] clk_st;
  assign clk_st = in_st.drv_clk;

  always_comb begin
    for (int k = 0; k < NUM_DRV; k++) begin
      idle_hi[k] = (idle_ff[k] == IDLE_HIGH_CODE);
    end
  end

  // turning on only while the clock is low avoids a runt first pulse
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int k = 0; k < NUM_DRV; k++) begin
        state_ff[k] <= DRV_OFF;
      end
    end else begin
      for (int k = 0; k < NUM_DRV; k++) begin
        unique case (state_ff[k])
          DRV_ON: begin
            if (dis_req[k] && (!sync_mode_ff[k] || !clk_st[k])) begin
              state_ff[k] <= DRV_OFF;
            end
          end
          DRV_OFF: begin
            if (!dis_req[k] && !clk_st[k]) begin
              state_ff[k] <= DRV_ON;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      drv_out_ff <= '0;
    end else begin
      for (int k = 0; k < NUM_DRV; k++) begin
        drv_out_ff[k] <= (state_ff[k] == DRV_ON) ? clk_st[k]
                                                 : idle_hi[k];
      end
    end
  end

  always_comb begin
    for (int k = 0; k < NUM_DRV; k++) begin
      drv_active[k] = (state_ff[k] == DRV_ON);
    end
  end

  assign drv_out = drv_out_ff;
  assign driver_supply_level = sup_ff;
  // disable never powers the driver down
  assign drv_cm_keep = {NUM_DRV{1'b1}};

  ////////////////////////////////////////////////////////////////////////////
  // register read
  logic [7:0] rdata;
  logic [7:0] rdata_ff;
  always_comb begin
    rdata = RDATA_ZERO;
    if (reg_addr == ADDR_STAT_CAL) begin
      rdata[BIT_XSTAT] = in_st.crystal_loss;
      rdata[BIT_CALSTAT] = calibration_busy_flag;
    end
    if (reg_addr == ADDR_STAT_LOCK) begin
      rdata[NUM_LOOP-1:0] = in_st.lock_loss;
    end
    if (reg_addr == ADDR_GATE) begin
      rdata[BIT_GATE] = gate_ff;
    end
    if (reg_addr == ADDR_XMASK) begin
      rdata[BIT_XMASK] = xmask_ff;
    end
    if (reg_addr == ADDR_LMASK) begin
      rdata[NUM_LOOP-1:0] = lmask_ff;
    end
    if (reg_addr == ADDR_DRV_STAT) begin
      rdata[NUM_DRV-1:0] = drv_active;
    end
    for (int p = 0; p < NUM_PIN; p++) begin
      if (reg_addr == base_plus(ADDR_PINMAP_BASE, p)) begin
        rdata[NUM_DRV-1:0] = pinmap_ff[p];
      end
    end
    for (int k = 0; k < NUM_DRV; k++) begin
      if (reg_addr == base_plus(ADDR_LOOPSEL_BASE, k)) begin
        rdata[1:0] = loopsel_ff[k];
      end
      if (hit_en[k]) begin
        rdata[BIT_EN] = en_ff[k];
      end
      if (hit_cfg[k]) begin
        rdata[BIT_SYNC] = sync_mode_ff[k];
        rdata[IDLE_MSB:IDLE_LSB] = idle_ff[k];
      end
      if (hit_sup[k]) begin
        rdata[BIT_SUPV] = supv_ff[k];
        rdata[SUP_MSB:SUP_LSB] = sup_ff[k];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_ff <= RDATA_ZERO;
    end else if (reg_rd) begin
      rdata_ff <= rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // each input bit may only move in a cycle where its own stages agreed
  a_input_filter: assert property (
    @(posedge mclk) disable iff (!reset_n)
    ((stable_ff ^ $past(stable_ff)) & ($past(sync2_ff) ^ $past(sync3_ff)))
      == '0 || $past(!reset_n))
    else $error("filtered input moved without agreement");
  a_cm_kept: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (drv_active != {NUM_DRV{1'b1}}) |-> (drv_cm_keep == {NUM_DRV{1'b1}}))
    else $error("common mode dropped on disabled driver");
  a_pinmap_reset: assert property (
    @(posedge mclk) $rose(reset_n) |-> (pinmap_ff[0] == PINMAP0_RST)
      && (pinmap_ff[1] == PINMAP_OTHER_RST)
      && (pinmap_ff[2] == PINMAP_OTHER_RST))
    else $error("enable pin map wrong after reset");
  for (genvar g = 0; g < NUM_DRV; g++) begin : g_chk
    a_gate_off: assert property (
      @(posedge mclk) disable iff (!reset_n) !gate_ff |-> dis_req[g])
      else $error("gate low did not disable driver");
    a_enable_bit: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (!en_ff[g] || pin_dis[g]) |-> dis_req[g])
      else $error("driver enable not respected");
    a_pin_high: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (pinmap_ff[0][g] && in_st.pin_n[0]) |-> dis_req[g])
      else $error("high enable pin did not disable");
    a_crystal_loss: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (in_st.crystal_loss && !xmask_ff) |-> dis_req[g])
      else $error("crystal loss did not disable");
    a_lock_loss: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (in_st.lock_loss[loopsel_ff[g]] && !lmask_ff[loopsel_ff[g]])
        |-> dis_req[g])
      else $error("lock loss did not disable");
    // sync mode may legally hold on through a long high phase
    a_cal_busy: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (calibration_busy_flag && !sync_mode_ff[g])
        |=> (state_ff[g] == DRV_OFF))
      else $error("calibration flag did not stop driver");
    a_async_off: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (drv_active[g] && dis_req[g] && !sync_mode_ff[g])
        |=> !drv_active[g] ##1 (drv_out[g] == $past(idle_hi[g])))
      else $error("async disable not immediate");
    a_sync_wait: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (drv_active[g] && sync_mode_ff[g] && clk_st[g])
        |=> drv_active[g])
      else $error("sync disable cut a period");
    a_idle_level: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (!drv_active[g] && $stable(idle_hi[g]))
        |=> (drv_out[g] == $past(idle_hi[g])))
      else $error("idle level wrong");
    a_resume_clear: assert property (
      @(posedge mclk) disable iff (!reset_n)
      $rose(drv_active[g]) |-> $past(!dis_req[g]) && $past(!clk_st[g]))
      else $error("driver resumed with source active");
    a_mode_reset: assert property (
      @(posedge mclk) $rose(reset_n) |-> !sync_mode_ff[g])
      else $error("mode bit not async after reset");
    a_supply_legal: assert property (
      @(posedge mclk) disable iff (!reset_n)
      driver_supply_level[g] != SUP_RESERVED)
      else $error("reserved supply code stored");
  end

endmodule : output_disable_control

/* File: testbench/output_disable_control_test.sv */
`timescale 1ns/1ps
module output_disable_control_test;
  import out_disable_pkg::*;
  ////////////////////////////////////////////////////////////
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic cal = 1'b0;
  logic xl = 1'b0;
  logic [3:0] ll = 4'h0;
  logic [2:0] pins = 3'h0;
  logic man_mode = 1'b0;
  logic man_clk = 1'b0;
  logic [2:0] div = 3'h0;
  async_in_type src;
  logic [NUM_DRV-1:0] drv_out;
  logic [NUM_DRV-1:0] drv_active;
  logic [NUM_DRV-1:0] drv_cm_keep;
  logic [NUM_DRV-1:0][1:0] sup;
  int err_count = 0;
  int total_checks = 0;
  ////////////////////////////////////////////////////////////
  always #12.5 mclk = ~mclk;
  // driver clocks at mclk/8, inside the tracked range
  always @(posedge mclk) div <= div + 3'h1;
  assign src = '{drv_clk: man_mode ? {NUM_DRV{man_clk}} : {NUM_DRV{div[2]}},
                 lock_loss: ll, crystal_loss: xl, pin_n: pins};
  output_disable_control i_dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .async_in(src),
    .calibration_busy_flag(cal),
    .drv_out(drv_out),
    .drv_active(drv_active),
    .drv_cm_keep(drv_cm_keep),
    .driver_supply_level(sup)
  );
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #2;
    end
  endtask : tick
  task automatic chk_reg(input string nm, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_drv(input string nm, input logic [NUM_DRV-1:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_drv
  // strobe dropped then one idle edge, so calls never collide
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rdchk(input string nm, input logic [15:0] a,
                       input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk_reg(nm, e, reg_rdata);
    tick(1);
  endtask : rdchk
  // bounded at 60 cycles, well above synchronisers plus a driver clock half period
  task automatic wait_act(input logic [NUM_DRV-1:0] e);
    int i;
    i = 0;
    while (drv_active !== e && i < 60) begin
      tick(1);
      i++;
    end
    chk_drv("drv_active", e, drv_active);
    if (drv_active !== e) tally_and_finish();
  endtask : wait_act
  ////////////////////////////////////////////////////////////
  initial begin
    tick(12);
    reset_n = 1'b1;
    rdchk("gate", ADDR_GATE, 8'h01);
    rdchk("xmask", ADDR_XMASK, 8'h00);
    rdchk("lmask", ADDR_LMASK, 8'h0F);
    rdchk("map0", ADDR_PINMAP_BASE, 8'h7F);
    rdchk("map1", ADDR_PINMAP_BASE + 16'h0001, 8'h00);
    rdchk("map2", ADDR_PINMAP_BASE + 16'h0002, 8'h00);
    rdchk("unmapped", 16'h0100, 8'h00);
    for (int k = 0; k < NUM_DRV; k++) begin
      rdchk("en", ADDR_EN[k], 8'h02);
      rdchk("cfg", ADDR_CFG[k], 8'h00);
      rdchk("sup", ADDR_SUP[k], 8'h08);
    end
    chk_drv("cm_keep", 7'h7F, drv_cm_keep);
    wait_act(7'h7F);
    $display("test reset done");
    wr(ADDR_CFG[0], 8'h10);
    wr(ADDR_CFG[1], 8'h20);
    wr(ADDR_GATE, 8'h00);
    wait_act(7'h00);
    tick(2);
    chk_drv("idle", 7'h01, drv_out);
    chk_drv("cm_keep", 7'h7F, drv_cm_keep);
    wr(ADDR_GATE, 8'h01);
    wait_act(7'h7F);
    wr(ADDR_CFG[0], 8'h00);
    wr(ADDR_CFG[1], 8'h00);
    $display("test gate done");
    pins = 3'b110;
    tick(8);
    chk_drv("pins12", 7'h7F, drv_active);
    pins = 3'b111;
    wait_act(7'h00);
    wr(ADDR_PINMAP_BASE + 16'h0001, 8'h08);
    pins = 3'b010;
    wait_act(7'h77);
    rdchk("drv_stat", ADDR_DRV_STAT, 8'h77);
    pins = 3'b000;
    wait_act(7'h7F);
    $display("test pins done");
    wr(ADDR_EN[2], 8'h00);
    wait_act(7'h7B);
    wr(ADDR_EN[2], 8'h02);
    wait_act(7'h7F);
    $display("test enable done");
    xl = 1'b1;
    wait_act(7'h00);
    rdchk("xstat", ADDR_STAT_CAL, 8'h02);
    wr(ADDR_XMASK, 8'h40);
    wait_act(7'h7F);
    xl = 1'b0;
    wr(ADDR_XMASK, 8'h00);
    wait_act(7'h7F);
    $display("test crystal done");
    ll = 4'h1;
    tick(8);
    chk_drv("lockmask", 7'h7F, drv_active);
    rdchk("lstat", ADDR_STAT_LOCK, 8'h01);
    wr(ADDR_LMASK, 8'h0E);
    wait_act(7'h00);
    wr(ADDR_LOOPSEL_BASE + 16'h0004, 8'h01);
    wait_act(7'h10);
    ll = 4'h0;
    wait_act(7'h7F);
    wr(ADDR_LMASK, 8'h0F);
    $display("test lock done");
    // masks wide open: calibration must still win
    wr(ADDR_XMASK, 8'h40);
    cal = 1'b1;
    wait_act(7'h00);
    rdchk("calstat", ADDR_STAT_CAL, 8'h01);
    cal = 1'b0;
    wait_act(7'h7F);
    wr(ADDR_XMASK, 8'h00);
    $display("test calibration done");
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_SUP[5], {2'b00, 2'(c), 4'h8});
      chk_reg("supply", 8'(c), {6'h00, sup[5]});
    end
    wr(ADDR_SUP[5], 8'h38);
    rdchk("sup_rsvd", ADDR_SUP[5], 8'h28);
    chk_reg("supply", 8'h02, {6'h00, sup[5]});
    $display("test supply done");
    // clocks held by hand so a period can be caught half way
    man_mode = 1'b1;
    tick(8);
    man_clk = 1'b1;
    tick(8);
    chk_drv("clk_high", 7'h7F, drv_out);
    wr(ADDR_GATE, 8'h00);
    tick(2);
    chk_drv("async", 7'h00, drv_out);
    man_clk = 1'b0;
    wr(ADDR_GATE, 8'h01);
    wait_act(7'h7F);
    man_clk = 1'b1;
    tick(8);
    wr(ADDR_CFG[0], 8'h08);
    wr(ADDR_GATE, 8'h00);
    tick(2);
    chk_drv("sync_hold", 7'h01, drv_out);
    man_clk = 1'b0;
    wait_act(7'h00);
    tick(2);
    chk_drv("sync_idle", 7'h00, drv_out);
    man_mode = 1'b0;
    wr(ADDR_GATE, 8'h01);
    wait_act(7'h7F);
    $display("test sync done");
    // second reset mid-run must undo the map, mode and loop changes
    reset_n = 1'b0;
    tick(4);
    chk_drv("out_rst", 7'h00, drv_out);
    chk_drv("act_rst", 7'h00, drv_active);
    reset_n = 1'b1;
    rdchk("map1_rst", ADDR_PINMAP_BASE + 16'h0001, 8'h00);
    rdchk("cfg0_rst", ADDR_CFG[0], 8'h00);
    rdchk("loop4_rst", ADDR_LOOPSEL_BASE + 16'h0004, 8'h00);
    wait_act(7'h7F);
    $display("test reset again done");
    tally_and_finish();
  end
endmodule : output_disable_control_test
